//--- lpmc_pkg.sv
// Constants shared by the low power mode controller and its oscillator settle timer.
// Assumes a 40 MHz system clock that keeps running while the controller is in deep sleep.
package lpmc_pkg;

   // ==========================================================================
   // Register map (byte addresses on the Wishbone bus)
   // ==========================================================================
   localparam logic [31:0] LPMC_ADDR_POWER_MODE  = 32'he01fc0c0;
   localparam logic [31:0] LPMC_ADDR_CLOCK_GATES = 32'he01fc0c4;

   // ==========================================================================
   // Field positions and reset values
   // ==========================================================================
   localparam int          LPMC_NAP_BIT          = 0;
   localparam int          LPMC_DEEP_BIT         = 1;
   localparam int          LPMC_MON_OFF_BIT      = 2;
   localparam logic [2:0]  LPMC_POWER_MODE_RST   = 3'h0;
   localparam logic [31:0] LPMC_CLOCK_GATES_RST  = 32'h001817be;
   // Only implemented peripheral gates hold a value; reserved bits read zero.
   localparam logic [31:0] LPMC_CLOCK_GATES_MASK = 32'h001817be;

   // ==========================================================================
   // Timing
   // ==========================================================================
   localparam int          LPMC_CLK_PERIOD_PS    = 25000;
   localparam int          LPMC_OSC_SETTLE_NS    = 50000;
   localparam int          LPMC_OSC_SETTLE_CYC   =
      (LPMC_OSC_SETTLE_NS * 1000 + LPMC_CLK_PERIOD_PS - 1) / LPMC_CLK_PERIOD_PS;
   localparam int          LPMC_TIMER_W          = 12;

   // ==========================================================================
   // Controller states
   // ==========================================================================
   typedef enum logic [1:0] {
      LPMC_ST_RUN,
      LPMC_ST_NAP,
      LPMC_ST_DEEP,
      LPMC_ST_OSC_WAIT
   } lpmc_state_e;

endpackage : lpmc_pkg

//--- lpmc_wake_timer.sv
// Oscillator settle timer: counts while start_i is high and then raises done_o.
// Assumes start_i comes from logic on the same clock and is held for the whole wait.
`timescale 1ns/1ps
`default_nettype none
module lpmc_wake_timer
   import lpmc_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   input  wire logic start_i,
   output logic      done_o
);
   import lpmc_pkg::*;

   localparam logic [LPMC_TIMER_W-1:0] SETTLE_LAST = LPMC_TIMER_W'(LPMC_OSC_SETTLE_CYC - 1);

   logic [LPMC_TIMER_W-1:0] count_r;

   // ==========================================================================
   // Settle counter
   // ==========================================================================
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         count_r <= '0;
      end else if (!start_i) begin
         count_r <= '0;
      end else if (count_r != SETTLE_LAST) begin
         count_r <= count_r + 1'b1;
      end
   end

   assign done_o = start_i && (count_r == SETTLE_LAST);

   // ==========================================================================
   // Checks
   // ==========================================================================
   logic [LPMC_TIMER_W-1:0] run_len_r;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         run_len_r <= '0;
      end else if (!start_i) begin
         run_len_r <= '0;
      end else if (run_len_r != '1) begin
         run_len_r <= run_len_r + 1'b1;
      end
   end

   chk_settle_length: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      done_o |-> (run_len_r == SETTLE_LAST))
      else $error("settle timer finished after the wrong number of cycles");

endmodule : lpmc_wake_timer
`default_nettype wire

//--- lpmc_top.sv
// Low power mode controller: power mode and peripheral clock gate registers on Wishbone,
// with clock, oscillator, pin hold and supply monitor controls for the rest of the chip.
// Assumes clk_i keeps running in deep sleep and the core reports when it is at an
// instruction boundary where its clock may be stopped.
//
// Overview of operation
// - Writing a one to either mode bit starts the matching reduced power mode.
// - Light sleep stops the processor clock while peripherals stay clocked.
// - Light sleep lasts until reset or an enabled peripheral or external interrupt.
// - Light sleep also stops memory, memory controller and internal bus clocks.
// - Deep sleep stops the oscillator and every on-chip clock.
// - With both mode bits set, deep sleep is entered.
// - Deep sleep keeps all state and holds the pin levels static.
// - Deep sleep ends only on reset or on a wake source that needs no clock.
// - An external wake from deep sleep restarts the oscillator, clears the deep bit and resumes.
// - After a deep wake the processor waits until the oscillator settle timer expires.
// - Sleep entry and wake fall on instruction boundaries so nothing is lost or repeated.
// - In deep sleep with the monitor-off bit clear, the supply monitor runs and its trip wakes the chip.
// - In deep sleep with the monitor-off bit set, the supply monitor is switched off.
// - Without the deep bit, the monitor-off bit does not affect the supply monitor.
// - Each peripheral clock gate bit, when set, lets the clock of its peripheral run; a clear bit gates it off.
//
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module lpmc_top
   import lpmc_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rstn_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [31:0] wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        core_at_boundary_i,
   input  wire logic        irq_wake_i,
   input  wire logic        ext_wake_i,
   input  wire logic        monitor_trip_i,
   output logic             cpu_clk_en_o,
   output logic             mem_bus_clk_en_o,
   output logic [31:0]      periph_clk_en_o,
   output logic             osc_en_o,
   output logic             pins_hold_o,
   output logic             monitor_en_o,
   output logic             monitor_reset_o
);
   import lpmc_pkg::*;

   // ==========================================================================
   // Reset release
   // ==========================================================================
   logic [1:0] rst_sync_r;
   logic       rst_n;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end

   assign rst_n = rst_sync_r[1];

   // ==========================================================================
   // Pin synchronisers
   // ==========================================================================
   // Index 0 is the external wake pin, index 1 the supply monitor trip.
   logic [1:0] pin_raw;
   logic [1:0] pin_s1_r;
   logic [1:0] pin_s2_r;
   logic [1:0] pin_s3_r;
   logic [1:0] pin_f_r;
   logic       ext_wake;
   logic       monitor_trip;

   assign pin_raw = {monitor_trip_i, ext_wake_i};

   generate
      for (genvar gi = 0; gi < 2; gi++) begin : g_pin
         always_ff @(posedge clk_i or negedge rst_n) begin
            if (!rst_n) begin
               pin_s1_r[gi] <= 1'b0;
               pin_s2_r[gi] <= 1'b0;
               pin_s3_r[gi] <= 1'b0;
               pin_f_r[gi]  <= 1'b0;
            end else begin
               pin_s1_r[gi] <= pin_raw[gi];
               pin_s2_r[gi] <= pin_s1_r[gi];
               pin_s3_r[gi] <= pin_s2_r[gi];
               // A level counts only once two later stages agree on it.
               if (pin_s2_r[gi] == pin_s3_r[gi]) begin
                  pin_f_r[gi] <= pin_s3_r[gi];
               end
            end
         end
      end
   endgenerate

   assign ext_wake     = pin_f_r[0];
   assign monitor_trip = pin_f_r[1];

   // ==========================================================================
   // Wishbone slave
   // ==========================================================================
   logic        ack_r;
   logic        req;
   logic        hit_mode;
   logic        hit_gates;
   logic        wr_mode;
   logic        wr_gates;
   logic [31:0] rd_data_r;
   logic [2:0]  mode_r;
   logic [31:0] gates_r;
   logic [31:0] sel_mask;

   assign req       = wb_cyc_i && wb_stb_i;
   assign hit_mode  = (wb_adr_i[31:2] == LPMC_ADDR_POWER_MODE[31:2]);
   assign hit_gates = (wb_adr_i[31:2] == LPMC_ADDR_CLOCK_GATES[31:2]);
   // Writes land on the edge that closes the acknowledge cycle.
   assign wr_mode   = req && wb_we_i && ack_r && hit_mode && wb_sel_i[0];
   assign wr_gates  = req && wb_we_i && ack_r && hit_gates;
   assign sel_mask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= req && !ack_r;
      end
   end

   // Unmapped addresses acknowledge with zero data and ignore writes.
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         rd_data_r <= 32'h0;
      end else if (req && !ack_r) begin
         if (hit_mode) begin
            rd_data_r <= {29'h0, mode_r};
         end else if (hit_gates) begin
            rd_data_r <= gates_r;
         end else begin
            rd_data_r <= 32'h0;
         end
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = rd_data_r;

   // ==========================================================================
   // Controller state
   // ==========================================================================
   lpmc_state_e state_r;
   lpmc_state_e state_nxt;
   logic        settle_done;
   logic        deep_trip;

   assign deep_trip = monitor_trip && !mode_r[LPMC_MON_OFF_BIT];

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         LPMC_ST_RUN: begin
            // The core stops only at an instruction boundary.
            if (core_at_boundary_i && mode_r[LPMC_DEEP_BIT]) begin
               state_nxt = LPMC_ST_DEEP;
            end else if (core_at_boundary_i && mode_r[LPMC_NAP_BIT]) begin
               state_nxt = LPMC_ST_NAP;
            end
         end
         LPMC_ST_NAP: begin
            if (irq_wake_i || ext_wake) begin
               state_nxt = LPMC_ST_RUN;
            end
         end
         LPMC_ST_DEEP: begin
            if (ext_wake || deep_trip) begin
               state_nxt = LPMC_ST_OSC_WAIT;
            end
         end
         LPMC_ST_OSC_WAIT: begin
            if (settle_done) begin
               state_nxt = LPMC_ST_RUN;
            end
         end
         default: begin
            state_nxt = LPMC_ST_RUN;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= LPMC_ST_RUN;
      end else begin
         state_r <= state_nxt;
      end
   end

   lpmc_wake_timer u_wake_timer (
      .clk_i   (clk_i),
      .rst_n_i (rst_n),
      .start_i (state_r == LPMC_ST_OSC_WAIT),
      .done_o  (settle_done)
   );

   // ==========================================================================
   // Registers
   // ==========================================================================
   // A software write wins over the hardware clear of the same cycle.
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         mode_r <= LPMC_POWER_MODE_RST;
      end else if (wr_mode) begin
         mode_r <= wb_dat_i[2:0];
      end else begin
         if (state_r == LPMC_ST_NAP && state_nxt == LPMC_ST_RUN) begin
            mode_r[LPMC_NAP_BIT] <= 1'b0;
         end
         if (state_r == LPMC_ST_DEEP && state_nxt == LPMC_ST_OSC_WAIT) begin
            mode_r[LPMC_DEEP_BIT] <= 1'b0;
            mode_r[LPMC_NAP_BIT]  <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         gates_r <= LPMC_CLOCK_GATES_RST;
      end else if (wr_gates) begin
         gates_r <= ((gates_r & ~sel_mask) | (wb_dat_i & sel_mask)) & LPMC_CLOCK_GATES_MASK;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         monitor_reset_o <= 1'b0;
      end else begin
         monitor_reset_o <= (state_r == LPMC_ST_DEEP) && deep_trip && !ext_wake;
      end
   end

   // ==========================================================================
   // Clock and power controls
   // ==========================================================================
   logic clocks_on;
   assign clocks_on        = (state_r == LPMC_ST_RUN);
   assign cpu_clk_en_o     = clocks_on;
   assign mem_bus_clk_en_o = clocks_on;
   assign periph_clk_en_o  = (clocks_on || state_r == LPMC_ST_NAP) ? gates_r : 32'h0;
   assign osc_en_o         = (state_r != LPMC_ST_DEEP);
   assign pins_hold_o      = (state_r == LPMC_ST_DEEP);
   assign monitor_en_o     = !(state_r == LPMC_ST_DEEP && mode_r[LPMC_MON_OFF_BIT]);

   // ==========================================================================
   // Checks
   // ==========================================================================
   chk_nap_clocks: assert property (@(posedge clk_i) disable iff (!rst_n)
      state_r == LPMC_ST_NAP |-> !cpu_clk_en_o && !mem_bus_clk_en_o && periph_clk_en_o == gates_r)
      else $error("light sleep clocks wrong");

   chk_deep_off: assert property (@(posedge clk_i) disable iff (!rst_n)
      state_r == LPMC_ST_DEEP |-> !osc_en_o && periph_clk_en_o == 32'h0 && pins_hold_o && !cpu_clk_en_o)
      else $error("deep sleep left a clock running");

   chk_deep_priority: assert property (@(posedge clk_i) disable iff (!rst_n)
      state_r == LPMC_ST_RUN && core_at_boundary_i && mode_r[LPMC_DEEP_BIT] && !wr_mode
      |=> state_r == LPMC_ST_DEEP)
      else $error("deep sleep not entered");

   chk_nap_wake: assert property (@(posedge clk_i) disable iff (!rst_n)
      state_r == LPMC_ST_NAP && irq_wake_i |=> state_r == LPMC_ST_RUN && !mode_r[LPMC_NAP_BIT])
      else $error("light sleep did not end on interrupt");

   chk_ext_wake: assert property (@(posedge clk_i) disable iff (!rst_n)
      state_r == LPMC_ST_DEEP && ext_wake
      |=> state_r == LPMC_ST_OSC_WAIT && osc_en_o && !mode_r[LPMC_DEEP_BIT])
      else $error("external wake did not restart the oscillator");

   chk_hold_exec: assert property (@(posedge clk_i) disable iff (!rst_n)
      state_r == LPMC_ST_OSC_WAIT && !settle_done |=> !cpu_clk_en_o)
      else $error("processor resumed before oscillator settled");

   chk_deep_exit: assert property (@(posedge clk_i) disable iff (!rst_n)
      state_r == LPMC_ST_DEEP && !ext_wake && !deep_trip |=> state_r == LPMC_ST_DEEP)
      else $error("deep sleep left without a wake source");

   chk_monitor_trip: assert property (@(posedge clk_i) disable iff (!rst_n)
      state_r == LPMC_ST_DEEP && deep_trip && !ext_wake |=> monitor_reset_o && state_r == LPMC_ST_OSC_WAIT)
      else $error("supply monitor trip did not release deep sleep");

   chk_monitor_off: assert property (@(posedge clk_i) disable iff (!rst_n)
      state_r == LPMC_ST_DEEP && mode_r[LPMC_MON_OFF_BIT] |-> !monitor_en_o)
      else $error("supply monitor left on in deep sleep");

   chk_monitor_awake: assert property (@(posedge clk_i) disable iff (!rst_n)
      !mode_r[LPMC_DEEP_BIT] |-> monitor_en_o)
      else $error("monitor-off bit acted without deep sleep");

   chk_entry_boundary: assert property (@(posedge clk_i) disable iff (!rst_n)
      $past(state_r) == LPMC_ST_RUN && state_r != LPMC_ST_RUN |-> $past(core_at_boundary_i))
      else $error("sleep entered off an instruction boundary");

   chk_gates_run: assert property (@(posedge clk_i) disable iff (!rst_n)
      wr_gates ##1 state_r == LPMC_ST_RUN |-> periph_clk_en_o == ($past(wb_dat_i) & LPMC_CLOCK_GATES_MASK)
         || $past(wb_sel_i) != 4'hf)
      else $error("peripheral gates do not follow the register");

   chk_mode_write: assert property (@(posedge clk_i) disable iff (!rst_n)
      wr_mode |=> mode_r == $past(wb_dat_i[2:0]))
      else $error("power mode write lost");

endmodule : lpmc_top
`default_nettype wire

//--- lpmc_core_model.sv
// Partner model: the processor core, which reaches instruction boundaries, and the wake sources.
// Assumes the bench orders each wake through go_i with a kind: 0 irq, 1 external pin, 2 monitor.
`timescale 1ns/1ps
`default_nettype none
module lpmc_core_model (
   input  wire logic       clk_i,
   input  wire logic [3:0] gap_i,
   input  wire logic       go_i,
   input  wire logic [1:0] kind_i,
   input  wire logic       cpu_clk_en_i,
   output logic            boundary_o,
   output logic            irq_o,
   output logic            ext_o,
   output logic            trip_o,
   output int              bad_entry_o
);
   logic [3:0] cnt_r  = 4'h0;
   logic [3:0] hold_r = 4'h0;
   logic [1:0] kind_r = 2'h0;
   logic       en_q   = 1'b1;
   logic       bnd_q  = 1'b0;
   initial boundary_o  = 1'b0;
   initial bad_entry_o = 0;
   // ==========================================================================
   // Core: a boundary every gap_i+1 clocked cycles; the clock may stop only there
   // ==========================================================================
   always @(posedge clk_i) begin
      if (cpu_clk_en_i) begin
         cnt_r <= (cnt_r >= gap_i) ? 4'h0 : cnt_r + 4'h1;
      end
      boundary_o <= cpu_clk_en_i && (cnt_r >= gap_i);
      en_q       <= cpu_clk_en_i;
      bnd_q      <= boundary_o;
      if (en_q && !cpu_clk_en_i && !bnd_q) begin
         bad_entry_o <= bad_entry_o + 1;
      end
   end
   // ==========================================================================
   // Wake sources: a level held eight cycles, long enough for the pin filter
   // ==========================================================================
   always @(posedge clk_i) begin
      if (go_i) begin
         hold_r <= 4'h8;
         kind_r <= kind_i;
      end else if (hold_r != 4'h0) begin
         hold_r <= hold_r - 4'h1;
      end
   end
   assign irq_o  = (hold_r != 4'h0) && (kind_r == 2'h0);
   assign ext_o  = (hold_r != 4'h0) && (kind_r == 2'h1);
   assign trip_o = (hold_r != 4'h0) && (kind_r == 2'h2);
endmodule : lpmc_core_model
`default_nettype wire

//--- lpmc_top_test.sv
// Self-checking bench for the low power mode controller.
// Assumes the partner model in lpmc_core_model.sv stands for the core and the wake sources.
`timescale 1ns/1ps
`default_nettype none
module lpmc_top_test;
   import lpmc_pkg::*;
   logic        clk_i = 1'b0;
   logic        rstn_i = 1'b0;
   logic        wb_cyc_i = 1'b0;
   logic        wb_stb_i = 1'b0;
   logic        wb_we_i = 1'b0;
   logic [31:0] wb_adr_i = 32'h0;
   logic [3:0]  wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o, bnd, irq, ext, trip, cpu_en, mem_en, osc_en, hold, mon_en, mon_rst;
   logic [31:0] per_en;
   logic [3:0]  gap = 4'h0;
   logic        go = 1'b0;
   logic [1:0]  kind = 2'h0;
   int          bad, err_count = 0, comparisons = 0, trips = 0, n, seed;
   logic [31:0] gv, exp_q[$];
   logic [2:0]  m;

   lpmc_top dut (.clk_i(clk_i), .rstn_i(rstn_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .core_at_boundary_i(bnd), .irq_wake_i(irq),
      .ext_wake_i(ext), .monitor_trip_i(trip), .cpu_clk_en_o(cpu_en), .mem_bus_clk_en_o(mem_en),
      .periph_clk_en_o(per_en), .osc_en_o(osc_en), .pins_hold_o(hold), .monitor_en_o(mon_en),
      .monitor_reset_o(mon_rst));
   lpmc_core_model core (.clk_i(clk_i), .gap_i(gap), .go_i(go), .kind_i(kind), .cpu_clk_en_i(cpu_en),
      .boundary_o(bnd), .irq_o(irq), .ext_o(ext), .trip_o(trip), .bad_entry_o(bad));

   initial begin
      forever #12.5 clk_i = ~clk_i;
   end
   // ==========================================================================
   // Shared tasks
   // ==========================================================================
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : conclude
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   // Classic cycle; request held until the edge that samples ack, then one idle cycle.
   task automatic wb(input logic we, input logic [31:0] adr, input logic [31:0] dat, input logic [3:0] sel);
      int k;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      wb_sel_i <= sel;
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (wb_ack_o !== 1'b1 && k < 20);
      if (k >= 20) begin
         err_count++;
         conclude();
      end
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
      @(posedge clk_i);
   endtask : wb
   task automatic rd(input logic [31:0] adr, input logic [31:0] exp);
      exp_q.push_back(exp);
      wb(1'b0, adr, 32'h0, 4'hf);
   endtask : rd
   // Read data is judged where it appears, against the oldest note.
   always @(posedge clk_i) begin
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0) begin
         check("read data", exp_q.pop_front(), wb_dat_o);
      end
      if (mon_rst === 1'b1) begin
         trips++;
      end
   end
   // Control order: cpu, memory and bus, oscillator, pin hold, monitor.
   task automatic outs(input logic [4:0] ctl, input logic [31:0] per);
      @(negedge clk_i);
      check("controls", {27'h0, ctl}, {27'h0, cpu_en, mem_en, osc_en, hold, mon_en});
      check("peripheral clocks", per, per_en);
      @(posedge clk_i);
   endtask : outs
   task automatic wait_cpu(input logic want, input int bound);
      n = 0;
      @(negedge clk_i);
      while (cpu_en !== want && n < bound) begin
         @(negedge clk_i);
         n++;
      end
      if (n >= bound) begin
         check("cpu clock wait", {31'h0, want}, {31'h0, cpu_en});
         conclude();
      end
      @(posedge clk_i);
   endtask : wait_cpu
   task automatic kick(input logic [1:0] k);
      kind <= k;
      go   <= 1'b1;
      @(posedge clk_i);
      go   <= 1'b0;
      @(posedge clk_i);
   endtask : kick
   initial begin
      #2500000;
      err_count++;
      conclude();
   end
   // ==========================================================================
   // Main sequence
   // ==========================================================================
   initial begin
      seed = $urandom(42);
      repeat (12) @(posedge clk_i);
      outs(5'b11101, LPMC_CLOCK_GATES_RST);
      rstn_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rd(LPMC_ADDR_POWER_MODE, 32'h0);
      rd(LPMC_ADDR_CLOCK_GATES, LPMC_CLOCK_GATES_RST);
      rd(32'he01fc0c8, 32'h0);
      gv = $urandom & LPMC_CLOCK_GATES_MASK;
      wb(1'b1, LPMC_ADDR_CLOCK_GATES, gv | ~LPMC_CLOCK_GATES_MASK, 4'hf);
      rd(LPMC_ADDR_CLOCK_GATES, gv);
      wb(1'b1, LPMC_ADDR_CLOCK_GATES, 32'h0, 4'h1);
      gv = gv & 32'hffffff00;
      rd(LPMC_ADDR_CLOCK_GATES, gv);
      outs(5'b11101, gv);
      $display("test registers done");
      wb(1'b1, LPMC_ADDR_POWER_MODE, 32'h1, 4'he);
      rd(LPMC_ADDR_POWER_MODE, 32'h0);
      for (int k = 0; k < 2; k++) begin
         gap <= 4'($urandom_range(7));
         wb(1'b1, LPMC_ADDR_POWER_MODE, 32'h5, 4'h1);
         wait_cpu(1'b0, 40);
         outs(5'b00101, gv);
         rd(LPMC_ADDR_POWER_MODE, 32'h5);
         kick(2'(k));
         wait_cpu(1'b1, 20);
         rd(LPMC_ADDR_POWER_MODE, 32'h4);
      end
      $display("test light sleep done");
      for (int k = 0; k < 3; k++) begin
         m = (k == 1) ? 3'h6 : 3'h3;
         gap <= 4'($urandom_range(7));
         trips = 0;
         wb(1'b1, LPMC_ADDR_POWER_MODE, {29'h0, m}, 4'h1);
         wait_cpu(1'b0, 40);
         outs({4'b0001, ~m[2]}, 32'h0);
         // With the monitor switched off, a supply trip must not end deep sleep either.
         kick((k == 1) ? 2'h2 : 2'h0);
         repeat (12) @(posedge clk_i);
         outs({4'b0001, ~m[2]}, 32'h0);
         if (k == 2) begin
            kick(2'h2);
         end else begin
            kick(2'h1);
         end
         repeat (10) @(posedge clk_i);
         outs(5'b00101, 32'h0);
         check("monitor reset pulses", (k == 2) ? 32'h1 : 32'h0, trips);
         wait_cpu(1'b1, 2100);
         check("settle wait", 32'h1, 32'(n > LPMC_OSC_SETTLE_CYC - 20 && n <= LPMC_OSC_SETTLE_CYC));
         rd(LPMC_ADDR_POWER_MODE, {29'h0, m & 3'h4});
         rd(LPMC_ADDR_CLOCK_GATES, gv);
         outs(5'b11101, gv);
      end
      $display("test deep sleep done");
      check("off-boundary entries", 32'h0, bad);
      conclude();
   end
endmodule : lpmc_top_test
`default_nettype wire
